// file: hw/spcs_port.sv
// How it works
// - a slave must run the srg at a quarter cpu clock, select and divide one
// - srg input tick is four cpu clocks, or the external srg clock when selected
// - master serial clock period is divide value plus one srg ticks, two when zero
// - high phase is div/2+1 ticks when even, (div+1)/2 when odd, one when zero
// - low phase is div/2 ticks when even, (div+1)/2 when odd, one when zero
// - as master with sync polarity one, frame sync out is active low select
// - as slave, the active-low select inputs are used directly as active-high deselects
// - master: tx clock and sync are outputs, rx clock and sync inputs
// - slave: all four clock and sync directions are inputs
// - master pulls select low before the enabling edge, transfer follows on clock
// - select-to-first-fall gap is one high phase (10b) or one period (11b)
// - mode 10b: each output bit is launched on a falling serial clock edge
// - mode 11b: the first output bit leads the clock, each later bit is launched on a rising serial clock edge
// - input data is sampled on the rising serial clock edge in both modes
// - data out floats after the last bit: master on rise, slave on deselect
`timescale 1ns/100ps
module spcs_port #(
  parameter int WORD_BITS = spcs_pkg::WORD_BITS,
  parameter int BUF_DEPTH = spcs_pkg::BUF_DEPTH
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] clock_stop_mode,
  input wire logic tx_clock_polarity,
  input wire logic tx_sync_polarity,
  input wire logic rx_sync_polarity,
  input wire logic tx_clock_direction,
  input wire logic rx_clock_direction,
  input wire logic tx_sync_direction,
  input wire logic rx_sync_direction,
  input wire logic srg_clock_select,
  input wire logic [7:0] srg_divide_value,
  input wire logic ext_srg_input_clock,
  input wire logic tx_serial_clock_in,
  output logic tx_serial_clock_out,
  output logic tx_serial_clock_oe,
  input wire logic tx_frame_sync_in,
  output logic tx_frame_sync_out,
  output logic tx_frame_sync_oe,
  input wire logic rx_frame_sync_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input wire logic [WORD_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [WORD_BITS-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic overrun_clear,
  output logic overrun,
  output logic cfg_fault,
  output logic busy
);

  localparam int CNT_W = $clog2(WORD_BITS + 1);

  // ----------------------------------------------------------------
  // pin synchronisers and srg tick
  // ----------------------------------------------------------------
  logic [2:0] cpu_cnt_reg;
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic din_s1_reg, din_s2_reg, din_s3_reg;
  logic cpu_tick, srg_tick, is_master, mode_full;
  logic [8:0] len_high, len_low, len_period;

  assign is_master = tx_clock_direction;
  assign mode_full = (clock_stop_mode == spcs_pkg::STOP_FULL);

  // three stages; a rise counts once stage two is high and stage three still low
  always_ff @(posedge mclk) begin
    ext_s1_reg <= ext_srg_input_clock;
    ext_s2_reg <= ext_s1_reg;
    ext_s3_reg <= ext_s2_reg;
    din_s1_reg <= serial_data_in;
    din_s2_reg <= din_s1_reg;
    din_s3_reg <= din_s2_reg;
  end

  // free-running cpu prescaler for the internal srg input
  always_ff @(posedge mclk) begin
    if (reset || cpu_tick) begin
      cpu_cnt_reg <= spcs_pkg::CPU_TICK_RST;
    end else begin
      cpu_cnt_reg <= cpu_cnt_reg + 3'h1;
    end
  end

  assign cpu_tick = (cpu_cnt_reg == spcs_pkg::CPU_TICK_LAST);
  assign srg_tick = srg_clock_select ? cpu_tick : (ext_s2_reg && !ext_s3_reg);
  assign len_high = spcs_pkg::spcs_phase_len(srg_divide_value, 1'h1);
  assign len_low = spcs_pkg::spcs_phase_len(srg_divide_value, 1'h0);
  assign len_period = len_high + len_low;

  // ----------------------------------------------------------------
  // transmit holding word
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] hold_reg;
  logic hold_valid_reg, tx_ready_reg, take_word, slv_ack_evt, mst_start;
  logic ack_s1_reg, ack_s2_reg, ack_s3_reg;

  assign take_word = mst_start || slv_ack_evt;

  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_valid_reg <= 1'h0;
      tx_ready_reg <= 1'h1;
    end else if (tx_valid && tx_ready_reg) begin
      hold_reg <= tx_data;
      hold_valid_reg <= 1'h1;
      tx_ready_reg <= 1'h0;
    end else if (take_word) begin
      hold_valid_reg <= 1'h0;
      tx_ready_reg <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // master sequencer
  // ----------------------------------------------------------------
  spcs_pkg::spcs_state_t st_reg;
  logic [8:0] len_reg;
  logic [CNT_W-1:0] bit_reg;
  logic [WORD_BITS-1:0] txsh_reg, rxsh_reg;
  logic sclk_reg, ss_reg, m_oe_reg, m_dout_reg, mst_push_reg, rxb_ready;
  logic last_tick;

  assign last_tick = srg_tick && (len_reg == 9'h001);
  assign mst_start = (st_reg == spcs_pkg::ST_IDLE) && srg_tick && is_master
      && hold_valid_reg && rxb_ready;

  // one process walks select, clock phases and data; counts in srg ticks
  always_ff @(posedge mclk) begin
    mst_push_reg <= 1'h0;
    if (reset) begin
      st_reg <= spcs_pkg::ST_IDLE;
      len_reg <= 9'h001;
      bit_reg <= '0;
      sclk_reg <= 1'h1;
      ss_reg <= 1'h0;
      m_oe_reg <= 1'h0;
      m_dout_reg <= 1'h0;
    end else begin
      if (srg_tick && len_reg != 9'h001) begin
        len_reg <= len_reg - 9'h001;
      end
      case (st_reg)
        spcs_pkg::ST_IDLE: begin
          sclk_reg <= 1'h1;
          if (mst_start) begin
            txsh_reg <= hold_reg;
            ss_reg <= 1'h1;
            bit_reg <= '0;
            st_reg <= spcs_pkg::ST_LEAD;
            len_reg <= mode_full ? len_period : len_high;
            if (mode_full) begin
              m_dout_reg <= hold_reg[WORD_BITS-1];
              m_oe_reg <= 1'h1;
            end
          end
        end
        spcs_pkg::ST_LEAD: begin
          if (last_tick) begin
            sclk_reg <= 1'h0;
            len_reg <= len_low;
            st_reg <= spcs_pkg::ST_LOW;
            if (!mode_full) begin
              m_dout_reg <= txsh_reg[WORD_BITS-1];
              m_oe_reg <= 1'h1;
            end
          end
        end
        spcs_pkg::ST_LOW: begin
          if (last_tick) begin
            sclk_reg <= 1'h1;
            rxsh_reg <= {rxsh_reg[WORD_BITS-2:0], din_s3_reg};
            bit_reg <= bit_reg + CNT_W'(1);
            if (bit_reg == CNT_W'(WORD_BITS - 1)) begin
              m_oe_reg <= 1'h0;
              len_reg <= mode_full ? len_high : len_period;
              st_reg <= spcs_pkg::ST_TAIL;
            end else begin
              len_reg <= len_high;
              st_reg <= spcs_pkg::ST_HIGH;
              if (mode_full) begin
                txsh_reg <= txsh_reg << 1;
                m_dout_reg <= txsh_reg[WORD_BITS-2];
              end
            end
          end
        end
        spcs_pkg::ST_HIGH: begin
          if (last_tick) begin
            sclk_reg <= 1'h0;
            len_reg <= len_low;
            st_reg <= spcs_pkg::ST_LOW;
            if (!mode_full) begin
              txsh_reg <= txsh_reg << 1;
              m_dout_reg <= txsh_reg[WORD_BITS-2];
            end
          end
        end
        spcs_pkg::ST_TAIL: begin
          if (last_tick) begin
            ss_reg <= 1'h0;
            mst_push_reg <= 1'h1;
            st_reg <= spcs_pkg::ST_IDLE;
          end
        end
        default: begin
          st_reg <= spcs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // slave logic on the incoming serial clock
  // ----------------------------------------------------------------
  logic rx_desel, tx_desel;
  logic [CNT_W-1:0] s_rcnt_reg, s_tcnt_reg;
  logic [WORD_BITS-1:0] s_rsh_reg, s_word_reg, s_tsh_reg;
  logic s_rtog_reg, s_atog_reg, s_fall_reg, s_rise_reg, s_oe_reg;
  logic rt_s1_reg, rt_s2_reg, rt_s3_reg, slv_evt;

  // active-low selects used directly as active-high deselects for the link logic
  assign rx_desel = rx_sync_polarity ? rx_frame_sync_in : !rx_frame_sync_in;
  assign tx_desel = tx_sync_polarity ? tx_frame_sync_in : !tx_frame_sync_in;

  // receive shifter; deselect clears it because the clock stops between words
  always_ff @(posedge tx_serial_clock_in or posedge rx_desel) begin
    if (rx_desel) begin
      s_rcnt_reg <= '0;
      s_rsh_reg <= '0;
    end else begin
      s_rsh_reg <= {s_rsh_reg[WORD_BITS-2:0], serial_data_in};
      s_rcnt_reg <= (s_rcnt_reg == CNT_W'(WORD_BITS - 1)) ? '0 : s_rcnt_reg + CNT_W'(1);
      if (s_rcnt_reg != CNT_W'(WORD_BITS - 1)) begin
        s_rise_reg <= s_tsh_reg[WORD_BITS - 2 - s_rcnt_reg];
      end
    end
  end

  // finished word stays put for a whole word time, long enough to cross
  always_ff @(posedge tx_serial_clock_in or posedge reset) begin
    if (reset) begin
      s_rtog_reg <= 1'h0;
      s_word_reg <= '0;
    end else if (!rx_desel && s_rcnt_reg == CNT_W'(WORD_BITS - 1)) begin
      s_word_reg <= {s_rsh_reg[WORD_BITS-2:0], serial_data_in};
      s_rtog_reg <= !s_rtog_reg;
    end
  end

  // first falling edge after select loads the word; float on deselect
  always_ff @(negedge tx_serial_clock_in or posedge tx_desel) begin
    if (tx_desel) begin
      s_tcnt_reg <= '0;
      s_oe_reg <= 1'h0;
    end else begin
      s_oe_reg <= 1'h1;
      if (s_tcnt_reg == '0) begin
        s_tsh_reg <= hold_reg;
        s_fall_reg <= hold_reg[WORD_BITS-1];
        s_tcnt_reg <= CNT_W'(1);
      end else if (s_tcnt_reg != CNT_W'(WORD_BITS)) begin
        s_fall_reg <= s_tsh_reg[WORD_BITS - 1 - s_tcnt_reg];
        s_tcnt_reg <= s_tcnt_reg + CNT_W'(1);
      end
    end
  end

  // word-taken toggle back to the holding register
  always_ff @(negedge tx_serial_clock_in or posedge reset) begin
    if (reset) begin
      s_atog_reg <= 1'h0;
    end else if (!tx_desel && s_tcnt_reg == '0) begin
      s_atog_reg <= !s_atog_reg;
    end
  end

  // toggles into mclk; event on disagreement of stages two and three
  always_ff @(posedge mclk) begin
    if (reset) begin
      {rt_s1_reg, rt_s2_reg, rt_s3_reg} <= 3'h0;
      {ack_s1_reg, ack_s2_reg, ack_s3_reg} <= 3'h0;
    end else begin
      {rt_s3_reg, rt_s2_reg, rt_s1_reg} <= {rt_s2_reg, rt_s1_reg, s_rtog_reg};
      {ack_s3_reg, ack_s2_reg, ack_s1_reg} <= {ack_s2_reg, ack_s1_reg, s_atog_reg};
    end
  end

  assign slv_evt = !is_master && (rt_s2_reg != rt_s3_reg);
  assign slv_ack_evt = !is_master && (ack_s2_reg != ack_s3_reg);

  // ----------------------------------------------------------------
  // receive buffer and status
  // ----------------------------------------------------------------
  logic overrun_reg, cfg_fault_reg;

  spcs_buf #(.W(WORD_BITS), .DEPTH(BUF_DEPTH)) u_rx_buf (
    .clk(mclk),
    .rst(reset),
    .in_valid(mst_push_reg || slv_evt),
    .in_ready(rxb_ready),
    .in_data(is_master ? rxsh_reg : s_word_reg),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // a slave cannot stall its master, so a full buffer drops the word
  always_ff @(posedge mclk) begin
    if (reset) begin
      overrun_reg <= 1'h0;
    end else if (slv_evt && !rxb_ready) begin
      overrun_reg <= 1'h1;
    end else if (overrun_clear) begin
      overrun_reg <= 1'h0;
    end
  end

  // flags settings that do not match the chosen role
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_fault_reg <= 1'h0;
    end else if (is_master) begin
      cfg_fault_reg <= !tx_sync_direction || rx_clock_direction || rx_sync_direction;
    end else begin
      cfg_fault_reg <= tx_sync_direction || rx_clock_direction || rx_sync_direction
          || srg_clock_select != spcs_pkg::SLAVE_SRG_SEL
          || srg_divide_value != spcs_pkg::SLAVE_SRG_DIV;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic fs_pin_reg, sclk_oe_reg, fs_oe_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      fs_pin_reg <= 1'h1;
      sclk_oe_reg <= 1'h0;
      fs_oe_reg <= 1'h0;
    end else begin
      fs_pin_reg <= tx_sync_polarity ? !ss_reg : ss_reg;
      sclk_oe_reg <= tx_clock_direction;
      fs_oe_reg <= tx_sync_direction;
    end
  end

  assign tx_serial_clock_out = sclk_reg;
  assign tx_serial_clock_oe = sclk_oe_reg;
  assign tx_frame_sync_out = fs_pin_reg;
  assign tx_frame_sync_oe = fs_oe_reg;
  // slave data picks the edge flop by mode and receive count (11b uses the fall flop while the count is zero); both are flops
  assign serial_data_out = is_master ? m_dout_reg
      : ((mode_full && s_rcnt_reg != '0) ? s_rise_reg : s_fall_reg);
  assign serial_data_out_oe = is_master ? m_oe_reg : s_oe_reg;
  assign tx_ready = tx_ready_reg;
  assign overrun = overrun_reg;
  assign cfg_fault = cfg_fault_reg;
  assign busy = ss_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [11:0] cyc_reg;
  logic [11:0] exp_high, exp_low, exp_lead;

  // cycles spent in the current state; the edge after a change still shows the full old count
  always_ff @(posedge mclk) begin
    if (reset || st_reg != $past(st_reg)) begin
      cyc_reg <= 12'h001;
    end else begin
      cyc_reg <= cyc_reg + 12'h001;
    end
  end

  assign exp_high = {1'h0, len_high, 2'h0};
  assign exp_low = {1'h0, len_low, 2'h0};
  assign exp_lead = mode_full ? {1'h0, len_period, 2'h0} : exp_high;

  srg_tick_a: assert property (@(posedge mclk) disable iff (reset)
      cpu_tick |=> !cpu_tick [*3] ##1 cpu_tick) else $error("srg tick not every four");
  high_len_a: assert property (@(posedge mclk) disable iff (reset)
      (srg_clock_select && st_reg == spcs_pkg::ST_LOW && $past(st_reg) == spcs_pkg::ST_HIGH)
      |-> cyc_reg == exp_high) else $error("high phase length wrong");
  low_len_a: assert property (@(posedge mclk) disable iff (reset)
      (srg_clock_select && $past(st_reg) == spcs_pkg::ST_LOW && st_reg != spcs_pkg::ST_LOW)
      |-> cyc_reg == exp_low) else $error("low phase length wrong");
  lead_len_a: assert property (@(posedge mclk) disable iff (reset)
      (srg_clock_select && $past(st_reg) == spcs_pkg::ST_LEAD && st_reg == spcs_pkg::ST_LOW)
      |-> cyc_reg == exp_lead && $fell(sclk_reg)) else $error("lead gap wrong");
  master_sel_a: assert property (@(posedge mclk) disable iff (reset)
      (is_master && tx_sync_polarity && st_reg == spcs_pkg::ST_LOW)
      |-> !tx_frame_sync_out) else $error("select not low during transfer");
  fall_launch_a: assert property (@(posedge mclk) disable iff (reset)
      (is_master && !mode_full && m_oe_reg && $changed(m_dout_reg))
      |-> $fell(sclk_reg)) else $error("bit not launched on fall");
  rise_launch_a: assert property (@(posedge mclk) disable iff (reset)
      (is_master && mode_full && $past(st_reg) != spcs_pkg::ST_IDLE && $changed(m_dout_reg))
      |-> $rose(sclk_reg)) else $error("bit not launched on rise");
  rise_sample_a: assert property (@(posedge mclk) disable iff (reset)
      (is_master && $changed(rxsh_reg)) |-> $rose(sclk_reg)) else $error("sample off rise");
  float_tail_a: assert property (@(posedge mclk) disable iff (reset)
      (st_reg == spcs_pkg::ST_TAIL) |-> !m_oe_reg ##1 !m_oe_reg) else $error("data not floated");
  idle_high_a: assert property (@(posedge mclk) disable iff (reset)
      (st_reg == spcs_pkg::ST_IDLE && $past(st_reg) == spcs_pkg::ST_IDLE)
      |-> sclk_reg) else $error("clock not parked high");

endmodule : spcs_port

// file: hw/spcs_pkg.sv
package spcs_pkg;

  // ----------------------------------------------------------------
  // serial word and clock-stop settings
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 8;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] STOP_HALF = 2'h2;
  localparam logic [1:0] STOP_FULL = 2'h3;

  // ----------------------------------------------------------------
  // sample-rate generator
  // ----------------------------------------------------------------
  // internal srg input clock is four cpu (mclk) periods
  localparam logic [2:0] CPU_TICK_DIV = 3'h4;
  localparam logic [2:0] CPU_TICK_LAST = CPU_TICK_DIV - 3'h1;
  localparam logic [2:0] CPU_TICK_RST = 3'h0;
  // settings a slave must run with (a quarter of the cpu clock)
  localparam logic SLAVE_SRG_SEL = 1'h1;
  localparam logic [7:0] SLAVE_SRG_DIV = 8'h01;

  // ----------------------------------------------------------------
  // master sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LEAD = 5'h02,
    ST_LOW  = 5'h04,
    ST_HIGH = 5'h08,
    ST_TAIL = 5'h10
  } spcs_state_t;

  // phase length in srg input ticks; zero divide clamps to one tick
  function automatic logic [8:0] spcs_phase_len(input logic [7:0] div, input logic high);
    logic [8:0] d;
    d = {1'h0, div};
    if (div == 8'h00) begin
      return 9'h001;
    end else if (!div[0]) begin
      return high ? (d >> 1) + 9'h001 : (d >> 1);
    end else begin
      return (d + 9'h001) >> 1;
    end
  endfunction : spcs_phase_len

endpackage : spcs_pkg

// file: hw/spcs_buf.sv
`timescale 1ns/100ps
module spcs_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] spcs_ptr_next(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : spcs_ptr_next

  // flags straight from the occupancy count, so full and empty are exact
  assign in_ready = (cnt_reg != CW'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage array, written only on an accepted push
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= spcs_ptr_next(wr_reg);
      end
      if (pop) begin
        rd_reg <= spcs_ptr_next(rd_reg);
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + CW'(1);
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end

endmodule : spcs_buf

// file: verif/spcs_partner.sv
`timescale 1ns/100ps
// ----------------------------------------
// far-side spi party, slave or master
// ----------------------------------------
module spcs_partner (
  input wire logic role_slave,
  input wire logic [1:0] mode,
  input wire logic sclk_w,
  input wire logic sel_w,
  input wire logic dout,
  output logic sclk,
  output logic sel,
  output logic din
);
  logic [7:0] s_word;
  logic [7:0] got;
  logic [7:0] sh;
  int n;
  // link clock and select stand high outside frames
  initial begin
    sclk = 1'h1;
    sel = 1'h1;
    din = 1'h0;
    s_word = 8'h00;
  end
  // slave role: first bit is ready at select fall
  always @(negedge sel_w) if (role_slave) begin
    sh = s_word;
    din = sh[7];
    n = 0;
  end
  // later bits change on falls, away from the sampling rise
  always @(negedge sclk_w) if (role_slave && !sel_w) begin
    if (n != 0) sh = {sh[6:0], 1'h0};
    din = sh[7];
    if (mode == spcs_pkg::STOP_FULL) got = {got[6:0], dout};
    n++;
  end
  always @(posedge sclk_w) if (role_slave && !sel_w && mode == spcs_pkg::STOP_HALF) begin
    got = {got[6:0], dout};
  end
  // a released line shows the inverse, never a stale bit
  always @(posedge sel_w) din = ~din;
  // master role: 32 ns link clock, only inside the frame
  task automatic frame(input logic [7:0] w, output logic [7:0] r);
    #3;
    sel = 1'h0;
    #48;
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'h0;
      din = w[i];
      #16;
      sclk = 1'h1;
      r[i] = dout;
      #16;
    end
    #32;
    sel = 1'h1;
    #64;
  endtask : frame
endmodule : spcs_partner

// file: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic mclk, reset, ext_clk, sel_src, tx_cd, tx_sd, rx_dir;
  logic [1:0] mode;
  logic [7:0] div, tx_data, rx_data, rx_word;
  logic tx_valid, tx_ready, rx_valid, rx_ready, ovc, overrun, cfg_fault, busy;
  logic sclk_o, sclk_oe, fs_o, fs_oe, dout, dout_oe, p_sclk, p_sel, din;
  int fail_count, samples_checked, hi_n, lo_n, hi_len, lo_len, gap, gap_done, tick, k, d;
  // clock and sync pin levels from the uut's enables, else the partner drives them
  wire sclk_w = sclk_oe ? sclk_o : p_sclk;
  wire fs_w = fs_oe ? fs_o : p_sel;
  spcs_port uut (.mclk(mclk), .reset(reset), .clock_stop_mode(mode),
    .tx_clock_polarity(1'h1), .tx_sync_polarity(1'h1), .rx_sync_polarity(1'h1),
    .tx_clock_direction(tx_cd), .rx_clock_direction(rx_dir),
    .tx_sync_direction(tx_sd), .rx_sync_direction(rx_dir),
    .srg_clock_select(sel_src), .srg_divide_value(div), .ext_srg_input_clock(ext_clk),
    .tx_serial_clock_in(sclk_w), .tx_serial_clock_out(sclk_o), .tx_serial_clock_oe(sclk_oe),
    .tx_frame_sync_in(fs_w), .tx_frame_sync_out(fs_o), .tx_frame_sync_oe(fs_oe),
    .rx_frame_sync_in(p_sel), .serial_data_in(din), .serial_data_out(dout),
    .serial_data_out_oe(dout_oe), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .overrun_clear(ovc), .overrun(overrun), .cfg_fault(cfg_fault), .busy(busy));
  spcs_partner p (.role_slave(tx_sd), .mode(mode), .sclk_w(sclk_w), .sel_w(fs_w),
    .dout(dout), .sclk(p_sclk), .sel(p_sel), .din(din));
  // ----------------------------------------
  // clocks, watchdog, phase counter
  // ----------------------------------------
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // offset keeps external clock edges clear of mclk edges
  initial begin
    ext_clk = 1'h0;
    #3;
    forever #30 ext_clk = ~ext_clk;
  end
  initial begin
    #300000;
    fail_count++;
    print_verdict();
  end
  // phase lengths in mclk cycles while a word is active
  always @(posedge mclk) begin
    if (!busy) begin
      hi_n <= 0;
      lo_n <= 0;
      gap_done <= 0;
    end else if (sclk_o) begin
      hi_n <= hi_n + 1;
      if (lo_n != 0) lo_len <= lo_n;
      lo_n <= 0;
    end else begin
      lo_n <= lo_n + 1;
      if (!gap_done) gap <= hi_n;
      else if (hi_n != 0) hi_len <= hi_n;
      gap_done <= 1;
      hi_n <= 0;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic int ph(input int v, input bit hi);
    if (v == 0) return 1;
    if (v % 2 == 0) return hi ? v / 2 + 1 : v / 2;
    return (v + 1) / 2;
  endfunction : ph
  // bounded wait on busy (0) or rx_valid (1)
  task automatic wait_on(input logic which, input logic lvl);
    int i;
    i = 0;
    #1;
    while ((which ? rx_valid : busy) !== lvl && i < 3000) begin
      @(posedge mclk);
      #1;
      i++;
    end
    if (i == 3000) check(16'h0001, 16'h0000);
  endtask : wait_on
  task automatic send_word(input logic [7:0] w);
    tx_data <= w;
    tx_valid <= 1'h1;
    @(posedge mclk);
    tx_valid <= 1'h0;
    @(posedge mclk);
  endtask : send_word
  task automatic read_word(input logic [7:0] w);
    wait_on(1'h1, 1'h1);
    check(16'(rx_data), 16'(w));
    @(posedge mclk);
    rx_ready <= 1'h1;
    @(posedge mclk);
    rx_ready <= 1'h0;
  endtask : read_word
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {reset, tx_cd, tx_sd, rx_dir, sel_src, ovc, tx_valid, rx_ready} = 8'hE8;
    mode = spcs_pkg::STOP_HALF;
    div = 8'h01;
    tx_data = 8'h00;
    repeat (3) @(posedge mclk);
    reset <= 1'h0;
    #1 check(16'({sclk_o, fs_o, dout_oe, tx_ready, rx_valid, busy, overrun}), 16'h0068);
    repeat (2) @(posedge mclk);
    #1 check(16'({cfg_fault, sclk_oe, fs_oe}), 16'h0003);
    @(posedge mclk);
    rx_dir <= 1'h1;
    repeat (3) @(posedge mclk);
    #1 check(16'(cfg_fault), 16'h0001);
    @(posedge mclk);
    rx_dir <= 1'h0;
    // master: both delay modes, four dividers, then the external srg clock
    for (k = 0; k < 9; k++) begin
      d = (k == 8) ? 1 : k % 4;
      mode <= (k < 4) ? spcs_pkg::STOP_HALF : spcs_pkg::STOP_FULL;
      div <= 8'(d);
      sel_src <= (k != 8);
      tick = (k == 8) ? 6 : 4;
      p.s_word = 8'hA5 ^ 8'(k);
      @(posedge mclk);
      send_word(8'h3C + 8'(k));
      wait_on(1'h0, 1'h1);
      wait_on(1'h0, 1'h0);
      check(16'(p.got), 16'h003C + 16'(k));
      read_word(8'hA5 ^ 8'(k));
      check(16'(gap), 16'(tick * (ph(d, 1) + ((k < 4) ? 0 : ph(d, 0)))));
      check(16'(hi_len), 16'(tick * ph(d, 1)));
      check(16'(lo_len), 16'(tick * ph(d, 0)));
      if (d != 0) check(16'(hi_len + lo_len), 16'(tick * (d + 1)));
      check(16'({dout_oe, sclk_o}), 16'h0001);
    end
    // slave: three frames (the middle one 11b) into a two-entry buffer, the last is lost
    tx_cd <= 1'h0;
    tx_sd <= 1'h0;
    mode <= spcs_pkg::STOP_HALF;
    div <= 8'h01;
    sel_src <= 1'h1;
    repeat (3) @(posedge mclk);
    #1 check(16'(cfg_fault), 16'h0000);
    for (k = 0; k < 3; k++) begin
      @(posedge mclk);
      mode <= (k == 1) ? spcs_pkg::STOP_FULL : spcs_pkg::STOP_HALF;
      send_word(8'h81 + 8'(k));
      repeat (8) @(posedge mclk);
      p.frame(8'h5A ^ 8'(k), rx_word);
      check(16'(rx_word), 16'h0081 + 16'(k));
      check(16'(dout_oe), 16'h0000);
    end
    repeat (6) @(posedge mclk);
    #1 check(16'(overrun), 16'h0001);
    read_word(8'h5A);
    read_word(8'h5B);
    ovc <= 1'h1;
    div <= 8'h02;
    @(posedge mclk);
    ovc <= 1'h0;
    repeat (3) @(posedge mclk);
    #1 check(16'({overrun, cfg_fault}), 16'h0001);
    print_verdict();
  end
endmodule : tb_top
